//--- core/ppi_port_regs.sv
// Port pin invert controls, port status and interrupt summary with an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
module ppi_port_regs #(
	parameter int PORTS = 12
) (
	input  wire logic                       ref_clk,
	input  wire logic                       reset_n,
	input  wire logic [7:0]                 avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [15:0]                avs_writedata,
	input  wire logic [1:0]                 avs_byteenable,
	output logic      [15:0]                avs_readdata,
	output logic                            avs_waitrequest,
	input  wire logic [$clog2(PORTS)-1:0]   port_index,
	input  wire logic                       perf_update_status,
	input  wire logic                       rx_line_clock_active,
	input  wire logic                       tx_input_clock_active,
	input  wire ppi_pkg::ppi_subblock_type  subblock_flags,
	input  wire ppi_pkg::ppi_tx_pins_type   tx_pins_raw,
	input  wire ppi_pkg::ppi_rx_pins_type   rx_pins_raw,
	output ppi_pkg::ppi_tx_pins_type        tx_pins,
	output ppi_pkg::ppi_rx_pins_type        rx_pins,
	output logic                            irq_n
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	localparam int SYNC_W = 5 + $bits(ppi_pkg::ppi_subblock_type) + 14;
	logic [SYNC_W-1:0] sync_stage1;
	logic [SYNC_W-1:0] sync_stage2;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_stage1 <= '0;
			sync_stage2 <= '0;
		end else begin
			sync_stage1 <= {perf_update_status, rx_line_clock_active, tx_input_clock_active, 2'b00,
				subblock_flags, tx_pins_raw, rx_pins_raw};
			sync_stage2 <= sync_stage1;
		end
	end

	logic                       perf_done;
	logic                       rx_clk_act;
	logic                       tx_clk_act;
	ppi_pkg::ppi_subblock_type  sub_s;
	ppi_pkg::ppi_tx_pins_type   tx_s;
	ppi_pkg::ppi_rx_pins_type   rx_s;
	assign perf_done  = sync_stage2[SYNC_W-1];
	assign rx_clk_act = sync_stage2[SYNC_W-2];
	assign tx_clk_act = sync_stage2[SYNC_W-3];
	assign sub_s      = sync_stage2[14 +: $bits(ppi_pkg::ppi_subblock_type)];
	assign tx_s       = sync_stage2[8 +: 6];
	assign rx_s       = sync_stage2[0 +: 8];

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	function automatic logic [15:0] ppi_merge(input logic [15:0] old, input logic [15:0] wdata,
		input logic [1:0] be, input logic [15:0] mask);
		logic [15:0] lanes;
		lanes = {{8{be[1]}}, {8{be[0]}}};
		ppi_merge = ((old & ~lanes) | (wdata & lanes)) & mask;
	endfunction

	// Register select for the write strobes; the read mux decodes with its own case
	function automatic logic ppi_hit(input logic [7:0] addr, input logic [7:0] target);
		ppi_hit = (addr == target);
	endfunction

	logic wr_cycle;
	logic rd_cycle;
	// Write lands at the edge that completes the transfer
	assign wr_cycle = avs_write && !avs_waitrequest;
	// Read data captured while the request waits
	assign rd_cycle = avs_read && avs_waitrequest;

	// ----------------------------------------------------------------
	// Write strobes
	// ----------------------------------------------------------------
	logic wr_ctrl4;
	logic wr_tx_invert;
	logic wr_rx_invert;
	logic wr_irq_enable;
	logic wr_global_en;
	logic wr_latched;
	assign wr_ctrl4      = wr_cycle && ppi_hit(avs_address, ppi_pkg::ppi_addr_ctrl4);
	assign wr_tx_invert  = wr_cycle && ppi_hit(avs_address, ppi_pkg::ppi_addr_tx_invert);
	assign wr_rx_invert  = wr_cycle && ppi_hit(avs_address, ppi_pkg::ppi_addr_rx_invert);
	assign wr_irq_enable = wr_cycle && ppi_hit(avs_address, ppi_pkg::ppi_addr_irq_enable);
	assign wr_global_en  = wr_cycle && ppi_hit(avs_address, ppi_pkg::ppi_addr_global_en);
	assign wr_latched    = wr_cycle && ppi_hit(avs_address, ppi_pkg::ppi_addr_latched);

	// One wait state: the answer comes at the second edge of a request
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	logic [15:0]      ctrl4;
	logic [15:0]      tx_invert;
	logic [15:0]      rx_invert;
	logic [15:0]      irq_enable;
	logic [PORTS-1:0] global_en;

	// Spare configuration bit; read back, and mirrored to live status bit 15
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl4 <= ppi_pkg::ppi_reg_reset;
		end else if (wr_ctrl4) begin
			ctrl4 <= ppi_merge(ctrl4, avs_writedata, avs_byteenable, ppi_pkg::ppi_ctrl4_mask);
		end
	end

	// Transmit pin polarity
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_invert <= ppi_pkg::ppi_reg_reset;
		end else if (wr_tx_invert) begin
			tx_invert <= ppi_merge(tx_invert, avs_writedata, avs_byteenable, ppi_pkg::ppi_tx_invert_mask);
		end
	end

	// Receive pin polarity, bits 9..6 held at zero
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_invert <= ppi_pkg::ppi_reg_reset;
		end else if (wr_rx_invert) begin
			rx_invert <= ppi_merge(rx_invert, avs_writedata, avs_byteenable, ppi_pkg::ppi_rx_invert_mask);
		end
	end

	// Interrupt enables, bits 2..1 held at zero
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_enable <= ppi_pkg::ppi_reg_reset;
		end else if (wr_irq_enable) begin
			irq_enable <= ppi_merge(irq_enable, avs_writedata, avs_byteenable,
				ppi_pkg::ppi_irq_enable_mask);
		end
	end

	// Per-port global interrupt enables
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			global_en <= '0;
		end else if (wr_global_en) begin
			global_en <= PORTS'(ppi_merge({4'h0, global_en}, avs_writedata, avs_byteenable, 16'h0fff));
		end
	end

	// ----------------------------------------------------------------
	// Live and latched status
	// ----------------------------------------------------------------
	logic [15:0] live_status;
	logic [15:0] latched;
	logic        spare_prev;
	logic        perf_prev;
	logic [15:0] latched_set;
	logic [15:0] latched_clr;

	always_comb begin
		live_status = 16'h0000;
		live_status[ppi_pkg::ppi_bit_spare]     = ctrl4[ppi_pkg::ppi_bit_spare];
		live_status[ppi_pkg::ppi_bit_perf_done] = perf_done;
	end

	// ----------------------------------------------------------------
	// Status edge history
	// ----------------------------------------------------------------
	// Previous spare level; a change either way latches
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			spare_prev <= 1'b0;
		end else begin
			spare_prev <= live_status[ppi_pkg::ppi_bit_spare];
		end
	end

	// Previous update level; only a rise latches
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			perf_prev <= 1'b0;
		end else begin
			perf_prev <= perf_done;
		end
	end

	always_comb begin
		latched_set = 16'h0000;
		latched_set[ppi_pkg::ppi_bit_spare]      = live_status[ppi_pkg::ppi_bit_spare] ^ spare_prev;
		latched_set[ppi_pkg::ppi_bit_rx_clk_act] = rx_clk_act;
		latched_set[ppi_pkg::ppi_bit_tx_clk_act] = tx_clk_act;
		latched_set[ppi_pkg::ppi_bit_perf_done]  = perf_done & ~perf_prev;
		latched_clr = 16'h0000;
		if (wr_latched) begin
			latched_clr = ppi_merge(16'h0000, avs_writedata, avs_byteenable, ppi_pkg::ppi_latched_mask);
		end
	end

	// Set wins over a simultaneous write-one clear
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			latched <= ppi_pkg::ppi_reg_reset;
		end else begin
			latched <= ((latched & ~latched_clr) | latched_set) & ppi_pkg::ppi_latched_mask;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt summary and output
	// ----------------------------------------------------------------
	logic [15:0] summary;
	logic        port_flag;
	logic        port_enabled;
	// Any enabled sticky flag of this port
	assign port_flag    = |(latched & irq_enable);
	// This port's bit of the global enable
	assign port_enabled = global_en[port_index];

	always_comb begin
		summary = 16'h0000;
		summary[ppi_pkg::ppi_bit_port_status] = port_flag;
		summary[8] = sub_s.line_coder_summary;
		summary[7] = sub_s.trail_trace_summary;
		summary[6] = sub_s.far_end_alarm_summary;
		summary[5] = sub_s.link_controller_summary;
		summary[4] = sub_s.bit_error_tester_summary;
		summary[3] = sub_s.system_fifo_summary;
		summary[2] = sub_s.cell_packet_summary;
		summary[1] = sub_s.convergence_layer_summary;
		summary[0] = sub_s.framer_summary;
	end

	// Summary reads live, so it drops once no enabled source remains
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= ~((|summary) & port_enabled);
		end
	end

	// ----------------------------------------------------------------
	// Transmit pin inversion
	// ----------------------------------------------------------------
	ppi_pkg::ppi_tx_pins_type next_tx_pins;
	ppi_pkg::ppi_rx_pins_type next_rx_pins;

	// One invert bit per transmit pin
	always_comb begin
		next_tx_pins                          = tx_s;
		next_tx_pins.tx_frame_start_in_invert = tx_s.tx_frame_start_in_invert ^ tx_invert[5];
		next_tx_pins.tx_negative_rail_invert  = tx_s.tx_negative_rail_invert ^ tx_invert[4];
		next_tx_pins.tx_positive_rail_invert  = tx_s.tx_positive_rail_invert ^ tx_invert[3];
		next_tx_pins.tx_line_clock_invert     = tx_s.tx_line_clock_invert ^ tx_invert[2];
		next_tx_pins.tx_clock_output_invert   = tx_s.tx_clock_output_invert ^ tx_invert[1];
		next_tx_pins.tx_clock_input_invert    = tx_s.tx_clock_input_invert ^ tx_invert[0];
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_pins <= '0;
		end else begin
			tx_pins <= next_tx_pins;
		end
	end

	// ----------------------------------------------------------------
	// Receive pin inversion
	// ----------------------------------------------------------------
	// Bits 9..6 and 0 select no pin
	always_comb begin
		next_rx_pins                           = rx_s;
		next_rx_pins.rx_packet_data_invert     = rx_s.rx_packet_data_invert ^ rx_invert[14];
		next_rx_pins.rx_overhead_enable_invert = rx_s.rx_overhead_enable_invert ^ rx_invert[13];
		next_rx_pins.rx_frame_start_out_invert = rx_s.rx_frame_start_out_invert ^ rx_invert[12];
		next_rx_pins.rx_serial_data_invert     = rx_s.rx_serial_data_invert ^ rx_invert[10];
		next_rx_pins.rx_negative_rail_invert   = rx_s.rx_negative_rail_invert ^ rx_invert[4];
		next_rx_pins.rx_positive_rail_invert   = rx_s.rx_positive_rail_invert ^ rx_invert[3];
		next_rx_pins.rx_line_clock_invert      = rx_s.rx_line_clock_invert ^ rx_invert[2];
		next_rx_pins.rx_clock_output_invert    = rx_s.rx_clock_output_invert ^ rx_invert[1];
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_pins <= '0;
		end else begin
			rx_pins <= next_rx_pins;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [15:0] next_readdata;

	// Unmapped offsets read zero
	always_comb begin
		next_readdata = 16'h0000;
		case (avs_address)
			ppi_pkg::ppi_addr_ctrl4:      next_readdata = ctrl4;
			ppi_pkg::ppi_addr_tx_invert:  next_readdata = tx_invert;
			ppi_pkg::ppi_addr_rx_invert:  next_readdata = rx_invert;
			ppi_pkg::ppi_addr_summary:    next_readdata = summary;
			ppi_pkg::ppi_addr_live:       next_readdata = live_status;
			ppi_pkg::ppi_addr_latched:    next_readdata = latched;
			ppi_pkg::ppi_addr_irq_enable: next_readdata = irq_enable;
			ppi_pkg::ppi_addr_global_en:  next_readdata = {4'h0, 12'(global_en)};
			default:                      next_readdata = 16'h0000;
		endcase
	end

	// Held until the next read, so it stands while waitrequest is low
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			avs_readdata <= 16'h0000;
		end else if (rd_cycle) begin
			avs_readdata <= next_readdata;
		end
	end

endmodule
`default_nettype wire

//--- pkg/ppi_pkg.sv
// Package: register map, field positions and carriers for the port pin invert and interrupt status block
// Functional notes
// - Tx invert bits 2..0 flip clock pins
// - Rx invert bits 14,13,12,10 flip data pins
// - Rx bits 4,3 flip rail inputs
// - Rx bits 2,1 flip clocks; 9..6 unused
// - Summary bit 9 from enabled latched status
// - Summary bits 8..4 from sub-block flags
// - Summary bits 3..0 from sub-block flags
// - Interrupt only when summary meets global enable
// - Live status 15 mirrors spare configuration bit
// - Live status 0 follows the synchronised update status
// - Latched 15 sets on spare bit change
// - Spare change enabled raises summary, interrupt
// - Latched 7,6 set on clock activity
// - Latched 0 sets on update done rise
// - Update done enabled raises summary, interrupt
// - Bits 1,2 unused; enables reset zero
// - Spare configuration bit readable, mirrored to live status 15
// - Tx bits 5,4,3 flip frame, rails
package ppi_pkg;

	localparam logic [7:0]  ppi_addr_ctrl4       = 8'h46;
	localparam logic [7:0]  ppi_addr_tx_invert   = 8'h4a;
	localparam logic [7:0]  ppi_addr_rx_invert   = 8'h4c;
	localparam logic [7:0]  ppi_addr_summary     = 8'h50;
	localparam logic [7:0]  ppi_addr_live        = 8'h52;
	localparam logic [7:0]  ppi_addr_latched     = 8'h54;
	localparam logic [7:0]  ppi_addr_irq_enable  = 8'h56;
	localparam logic [7:0]  ppi_addr_global_en   = 8'h58;

	localparam logic [15:0] ppi_tx_invert_mask   = 16'h003f;
	localparam logic [15:0] ppi_rx_invert_mask   = 16'h741e;
	localparam logic [15:0] ppi_ctrl4_mask       = 16'h8000;
	localparam logic [15:0] ppi_latched_mask     = 16'h80c1;
	localparam logic [15:0] ppi_irq_enable_mask  = 16'h8001;
	localparam logic [15:0] ppi_reg_reset        = 16'h0000;

	localparam int ppi_bit_spare       = 15;
	localparam int ppi_bit_rx_clk_act  = 7;
	localparam int ppi_bit_tx_clk_act  = 6;
	localparam int ppi_bit_perf_done   = 0;
	localparam int ppi_bit_port_status = 9;

	typedef struct packed {
		logic tx_frame_start_in_invert;
		logic tx_negative_rail_invert;
		logic tx_positive_rail_invert;
		logic tx_line_clock_invert;
		logic tx_clock_output_invert;
		logic tx_clock_input_invert;
	} ppi_tx_pins_type;

	typedef struct packed {
		logic rx_packet_data_invert;
		logic rx_overhead_enable_invert;
		logic rx_frame_start_out_invert;
		logic rx_serial_data_invert;
		logic rx_negative_rail_invert;
		logic rx_positive_rail_invert;
		logic rx_line_clock_invert;
		logic rx_clock_output_invert;
	} ppi_rx_pins_type;

	typedef struct packed {
		logic line_coder_summary;
		logic trail_trace_summary;
		logic far_end_alarm_summary;
		logic link_controller_summary;
		logic bit_error_tester_summary;
		logic system_fifo_summary;
		logic cell_packet_summary;
		logic convergence_layer_summary;
		logic framer_summary;
	} ppi_subblock_type;

endpackage

//--- sim/ppi_port_regs_checker.sv
// Checker: bus-visible relations of the port status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module ppi_port_regs_checker #(
	parameter int PORTS = 12
) (
	input wire logic                      ref_clk,
	input wire logic                      reset_n,
	input wire logic [7:0]                avs_address,
	input wire logic                      avs_read,
	input wire logic                      avs_write,
	input wire logic [15:0]               avs_writedata,
	input wire logic [15:0]               avs_readdata,
	input wire logic                      avs_waitrequest,
	input wire logic [$clog2(PORTS)-1:0]  port_index,
	input wire logic                      perf_update_status,
	input wire ppi_pkg::ppi_subblock_type subblock_flags,
	input wire logic                      irq_n
);
	logic      spare_q;
	logic      ge_q;
	wire logic wr_ok = avs_write && !avs_waitrequest;
	wire logic rd_ok = avs_read && !avs_waitrequest;
	// Shadow of spare bit and this port's global enable
	always_ff @(posedge ref_clk or negedge reset_n)
		if (!reset_n) {spare_q, ge_q} <= 2'h0;
		else if (wr_ok && avs_address == 8'h46) spare_q <= avs_writedata[15];
		else if (wr_ok && avs_address == 8'h58) ge_q <= avs_writedata[port_index];
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	property p_irq_off; (!ge_q) [*3] |-> irq_n; endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt with port disabled");
	property p_irq_on; (ge_q && |subblock_flags) [*6] |-> !irq_n; endproperty
	a_irq_on: assert property (p_irq_on) else $error("no interrupt for enabled source");
	property p_spare; rd_ok && avs_address == 8'h52 |-> avs_readdata[15] == spare_q; endproperty
	a_spare: assert property (p_spare) else $error("live spare bit differs");
	property p_perf; $stable(perf_update_status) [*6] ##0 (rd_ok && avs_address == 8'h52)
		|-> avs_readdata[0] == perf_update_status; endproperty
	a_perf: assert property (p_perf) else $error("live update bit differs");
	property p_sum; $stable(subblock_flags) [*6] ##0 (rd_ok && avs_address == 8'h50)
		|-> avs_readdata[8:0] == subblock_flags; endproperty
	a_sum: assert property (p_sum) else $error("summary sources differ");
	property p_sum_top; rd_ok && avs_address == 8'h50 |-> avs_readdata[15:10] == 6'h00; endproperty
	a_sum_top: assert property (p_sum_top) else $error("summary top bits set");
	property p_unused; rd_ok && avs_address inside {8'h52, 8'h54, 8'h56} |-> avs_readdata[2:1] == 2'h0; endproperty
	a_unused: assert property (p_unused) else $error("unused status bits set");
	property p_rx_unused; rd_ok && avs_address == 8'h4c |-> avs_readdata[9:6] == 4'h0; endproperty
	a_rx_unused: assert property (p_rx_unused) else $error("unused invert bits set");
endmodule
bind ppi_port_regs ppi_port_regs_checker #(.PORTS(PORTS)) ppi_port_regs_checker_i (.*);
`default_nettype wire

//--- sim/ppi_port_regs_tb.sv
// Testbench: registers, status latching and interrupt of the port block
`timescale 1ns/1ps
`default_nettype none
module ppi_port_regs_tb;
	logic                      ref_clk, reset_n, avs_read, avs_write, avs_waitrequest, irq_n;
	logic                      perf_update_status, rx_line_clock_active, tx_input_clock_active;
	logic [7:0]                avs_address;
	logic [15:0]               avs_writedata, avs_readdata, d, tx_inv, rx_inv;
	logic [3:0]                port_index;
	ppi_pkg::ppi_subblock_type subblock_flags;
	ppi_pkg::ppi_tx_pins_type  tx_pins_raw, tx_pins;
	ppi_pkg::ppi_rx_pins_type  rx_pins_raw, rx_pins;
	logic [7:0]                ra [6] = '{8'h4a, 8'h4c, 8'h46, 8'h56, 8'h58, 8'h60};
	logic [15:0]               rm [6] = '{16'h003f, 16'h741e, 16'h8000, 16'h8001, 16'h0fff, 16'h0000};
	int                        i, n_mismatch = 0, check_count = 0;
	always #25 ref_clk = ~ref_clk;
	ppi_port_regs #(.PORTS(12)) ppi_port_regs_i (.avs_byteenable(2'b11), .*);
	function automatic logic [15:0] rb(input int k, input logic [15:0] v);
		return v & rm[k];
	endfunction
	task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", w, e, g);
		end
	endtask
	// Read compares against v, write sends v
	task automatic acc(input logic w, input logic [7:0] adr, input logic [15:0] v);
		int n;
		n = 0;
		avs_address <= adr;
		avs_writedata <= v;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		if (!w)
			chk($sformatf("reg %h", adr), v, avs_readdata);
	endtask
	task automatic idle(input int n);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge ref_clk);
		n_mismatch++;
		close_out();
	end
	initial begin
		{ref_clk, reset_n, avs_read, avs_write, perf_update_status, rx_line_clock_active, tx_input_clock_active} = '0;
		{avs_address, avs_writedata, subblock_flags, tx_pins_raw, rx_pins_raw, tx_inv, rx_inv} = '0;
		void'($urandom(32'h498b_ab9e));
		port_index = 4'($urandom % 12);
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		foreach (ra[k]) acc(1'b0, ra[k], 16'h0000);
		$display("test reset values done");
		repeat (24) begin
			i = $urandom % 6;
			d = 16'($urandom);
			tx_pins_raw <= 6'($urandom);
			rx_pins_raw <= 8'($urandom);
			subblock_flags <= 9'($urandom);
			acc(1'b1, ra[i], d);
			if (i == 0)
				tx_inv = rb(i, d);
			if (i == 1)
				rx_inv = rb(i, d);
			acc(1'b0, ra[i], rb(i, d));
			idle(4);
			chk("tx_pins", {10'h000, tx_pins_raw ^ tx_inv[5:0]}, {10'h000, tx_pins});
			chk("rx_pins", {8'h00, rx_pins_raw ^ {rx_inv[14:12], rx_inv[10], rx_inv[4:1]}}, {8'h00, rx_pins});
		end
		$display("test read write done");
		acc(1'b1, 8'h58, 16'h0000);
		acc(1'b1, 8'h56, 16'h0000);
		acc(1'b1, 8'h46, 16'h0000);
		subblock_flags <= '0;
		idle(6);
		acc(1'b1, 8'h54, 16'hffff);
		acc(1'b1, 8'h46, 16'h8000);
		idle(6);
		acc(1'b0, 8'h52, 16'h8000);
		acc(1'b0, 8'h54, 16'h8000);
		acc(1'b1, 8'h54, 16'h8000);
		acc(1'b0, 8'h54, 16'h0000);
		acc(1'b1, 8'h46, 16'h0000);
		idle(6);
		acc(1'b0, 8'h54, 16'h8000);
		acc(1'b1, 8'h56, 16'h8000);
		acc(1'b1, 8'h58, 16'h0001 << port_index);
		idle(4);
		chk("irq_n", 16'h0000, {15'h0000, irq_n});
		acc(1'b0, 8'h50, 16'h0200);
		acc(1'b1, 8'h58, 16'h0000);
		idle(4);
		chk("irq_n", 16'h0001, {15'h0000, irq_n});
		acc(1'b1, 8'h58, 16'h0001 << port_index);
		acc(1'b1, 8'h54, 16'h8000);
		idle(4);
		chk("irq_n", 16'h0001, {15'h0000, irq_n});
		$display("test spare and interrupt done");
		perf_update_status <= 1'b1;
		idle(6);
		acc(1'b0, 8'h52, 16'h0001);
		acc(1'b0, 8'h54, 16'h0001);
		acc(1'b1, 8'h56, 16'h0001);
		idle(3);
		chk("irq_n", 16'h0000, {15'h0000, irq_n});
		acc(1'b1, 8'h54, 16'h0001);
		acc(1'b0, 8'h54, 16'h0000);
		perf_update_status <= 1'b0;
		idle(6);
		acc(1'b0, 8'h52, 16'h0000);
		rx_line_clock_active <= 1'b1;
		tx_input_clock_active <= 1'b1;
		idle(6);
		acc(1'b0, 8'h54, 16'h00c0);
		$display("test update and clock activity done");
		for (int k = 0; k < 9; k++) begin
			subblock_flags <= 9'h001 << k;
			idle(6);
			acc(1'b0, 8'h50, 16'h0001 << k);
			chk("irq_n", 16'h0000, {15'h0000, irq_n});
		end
		$display("test summary sources done");
		close_out();
	end
endmodule
`default_nettype wire
